// ### eecr_top.sv
// two-wire eeprom read side with protection and client address registers
`timescale 1ns/1ps
`include "eecr_map.svh"

module eecr_top #(
  parameter logic [3:0] DEV_TYPE      = `EECR_DEV_TYPE,  // arbitrary value
  parameter logic [2:0] CLIENT_PRESET = `EECR_CA_PRESET
) (
  // system clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // two-wire link, scl clocks the link logic
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_o,
  output logic                     sda_oe,
  // array fill port from the write path
  input  wire logic                mem_wr_en,
  input  wire eecr_pkg::eecr_addr_t mem_wr_addr,
  input  wire logic [7:0]          mem_wr_data,
  // protection query and settings
  input  wire eecr_pkg::eecr_addr_t chk_addr,
  output logic                     chk_protected,
  output eecr_pkg::eecr_cfg_t      cfg_out,
  output logic                     link_busy
);
  import eecr_pkg::*;

  logic [7:0]  mem [`EECR_DEPTH];

  eecr_state_t st_r, st_nxt;
  logic [2:0]  bitcnt_r, bitcnt_nxt;
  logic [7:0]  sh_r;
  logic        rw_r, rw_nxt;
  logic [7:0]  whi_r, whi_nxt;
  eecr_addr_t  ptr_r, ptr_nxt;
  logic        cfg_mode_r, cfg_mode_nxt;
  logic        cfg_idx_r, cfg_idx_nxt;
  logic [7:0]  obyte_r, obyte_nxt;
  logic        drv_r, drv_nxt;
  eecr_cfg_t   cfg_r, cfg_nxt;
  logic        cfg_tgl_r;
  logic        busy_r;
  logic        start_tgl_r;
  logic        start_seen_r;
  logic        sda_oe_r;
  logic        sda_o_r;
  logic        tg_s1_r, tg_s2_r, tg_s3_r;
  logic        bz_s1_r, bz_s2_r;
  eecr_cfg_t   cfg_out_r;
  logic        chk_prot_r;

  // array written on clk, read from the link side
  always_ff @(posedge clk) begin
    if (mem_wr_en) begin
      mem[mem_wr_addr] <= mem_wr_data;
    end
  end

  // start seen as sda falling while scl high; toggle so scl logic can compare
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_tgl_r <= 1'b0;
    end else if (scl_in) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  wire       start_pend = start_tgl_r ^ start_seen_r;
  wire [7:0] byte_in    = {sh_r[6:0], sda_in};
  wire       last_bit   = bitcnt_r == `EECR_LAST_BIT;
  wire       dev_match  = (byte_in[`EECR_DT_FIELD] == DEV_TYPE) &&
                          (byte_in[`EECR_CA_FIELD] == cfg_r.caddr);
  wire [7:0] prot_rd    = {`EECR_RSV_PROT, cfg_r.pe, cfg_r.pbs,
                           cfg_r.lock};
  wire [7:0] addr_rd    = {`EECR_RSV_ADDR, cfg_r.caddr};
  wire [7:0] cfg_rd     = cfg_idx_r ? addr_rd : prot_rd;
  wire [7:0] rd_byte    = cfg_mode_r ? cfg_rd : mem[ptr_r];
  wire       load       = (st_r == ST_AACK && rw_r) ||
                          (st_r == ST_RACK && !sda_in);
  wire       cfg_ok     = !cfg_r.lock && byte_in[`EECR_B_WE] &&
                          (byte_in[`EECR_B_CHK] ==
                           byte_in[`EECR_B_LOCK]);
  wire       cfg_wr     = st_r == ST_WDAT && last_bit && cfg_mode_r &&
                          cfg_ok && !start_pend;
  wire [`EECR_AW-1:0] word_ptr = {whi_r[`EECR_WA_HI], byte_in};
  wire       wa_done    = st_r == ST_WLO && last_bit && !start_pend;

  // protocol sequencing, one step per scl rising edge
  always_comb begin
    st_nxt     = st_r;
    bitcnt_nxt = bitcnt_r + `EECR_FIRST_BIT;
    drv_nxt    = 1'b0;
    rw_nxt     = rw_r;
    whi_nxt    = whi_r;
    if (start_pend) begin
      st_nxt     = ST_ADDR;
      bitcnt_nxt = `EECR_FIRST_BIT;
    end else begin
      case (st_r)
        ST_ADDR: begin
          if (last_bit) begin
            rw_nxt = byte_in[`EECR_RW_BIT];
            if (dev_match) begin
              st_nxt  = ST_AACK;
              drv_nxt = 1'b1;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
          if (rw_r) begin
            st_nxt  = ST_RDAT;
            drv_nxt = ~rd_byte[7];
          end else begin
            st_nxt = ST_WHI;
          end
        end
        ST_WHI: begin
          if (last_bit) begin
            whi_nxt = byte_in;
            st_nxt  = ST_WHACK;
            drv_nxt = 1'b1;
          end
        end
        ST_WHACK: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
          st_nxt     = ST_WLO;
        end
        ST_WLO: begin
          if (last_bit) begin
            st_nxt  = ST_WLACK;
            drv_nxt = 1'b1;
          end
        end
        ST_WLACK: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
          st_nxt     = ST_WDAT;
        end
        ST_WDAT: begin
          if (last_bit) begin
            st_nxt  = ST_WDACK;
            drv_nxt = 1'b1;
          end
        end
        ST_WDACK: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
          st_nxt     = ST_WDAT;
        end
        ST_RDAT: begin
          if (last_bit) begin
            st_nxt = ST_RACK;      // release so the host can answer
          end else begin
            drv_nxt = ~obyte_r[`EECR_NEXT_BIT - bitcnt_r];
          end
        end
        ST_RACK: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
          if (!sda_in) begin
            st_nxt  = ST_RDAT;
            drv_nxt = ~rd_byte[7];
          end else begin
            st_nxt = ST_IDLE;
          end
        end
        ST_IDLE: begin
          bitcnt_nxt = `EECR_BIT_ZERO;
        end
        default: begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // pointer, configuration and output byte updates
  always_comb begin
    ptr_nxt      = ptr_r;
    cfg_mode_nxt = cfg_mode_r;
    cfg_idx_nxt  = cfg_idx_r;
    obyte_nxt    = obyte_r;
    cfg_nxt      = cfg_r;
    if (load && !start_pend) begin
      obyte_nxt = rd_byte;
      if (cfg_mode_r) begin
        cfg_idx_nxt = ~cfg_idx_r;
      end else begin
        ptr_nxt = ptr_r + `EECR_PTR_ONE;
      end
    end
    if (wa_done) begin
      // word address is latched before any repeated start can arrive
      cfg_mode_nxt = whi_r[`EECR_WA_CFG];
      cfg_idx_nxt  = `EECR_PROT_IDX;
      if (!whi_r[`EECR_WA_CFG]) begin
        ptr_nxt = word_ptr;
      end
    end
    if (st_r == ST_WDAT && last_bit && cfg_mode_r && !start_pend) begin
      cfg_idx_nxt = ~cfg_idx_r;
    end
    if (cfg_wr) begin
      if (cfg_idx_r == `EECR_PROT_IDX) begin
        cfg_nxt.lock = byte_in[`EECR_B_LOCK];
        cfg_nxt.pe   = byte_in[`EECR_B_PE];
        cfg_nxt.pbs  = byte_in[`EECR_PBS_FIELD];
      end else begin
        cfg_nxt.caddr = byte_in[`EECR_CA_BITS];
      end
    end
  end

  always_ff @(posedge scl_in or posedge reset) begin
    if (reset) begin
      st_r         <= ST_IDLE;
      bitcnt_r     <= `EECR_BIT_ZERO;
      sh_r         <= 8'h00;
      rw_r         <= 1'b0;
      whi_r        <= 8'h00;
      start_seen_r <= 1'b0;
      drv_r        <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      bitcnt_r     <= bitcnt_nxt;
      sh_r         <= byte_in;
      rw_r         <= rw_nxt;
      whi_r        <= whi_nxt;
      start_seen_r <= start_tgl_r;
      drv_r        <= drv_nxt;
      busy_r       <= st_nxt != ST_IDLE;
    end
  end

  always_ff @(posedge scl_in or posedge reset) begin
    if (reset) begin
      ptr_r      <= `EECR_PTR_ZERO;
      cfg_mode_r <= 1'b0;
      cfg_idx_r  <= `EECR_PROT_IDX;
      obyte_r    <= 8'h00;
      cfg_r      <= '{1'b0, 1'b0, 2'h0, CLIENT_PRESET};
      cfg_tgl_r  <= 1'b0;
    end else begin
      ptr_r      <= ptr_nxt;
      cfg_mode_r <= cfg_mode_nxt;
      cfg_idx_r  <= cfg_idx_nxt;
      obyte_r    <= obyte_nxt;
      cfg_r      <= cfg_nxt;
      cfg_tgl_r  <= cfg_tgl_r ^ cfg_wr;
    end
  end

  // data changes only while scl is low
  always_ff @(negedge scl_in or posedge reset) begin
    if (reset) begin
      sda_oe_r <= 1'b0;
      sda_o_r  <= 1'b0;
    end else begin
      sda_oe_r <= drv_r;
      sda_o_r  <= 1'b0;
    end
  end

  // settings word crosses by toggle; cfg_r holds still for a whole byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tg_s1_r    <= 1'b0;
      tg_s2_r    <= 1'b0;
      tg_s3_r    <= 1'b0;
      bz_s1_r    <= 1'b0;
      bz_s2_r    <= 1'b0;
      cfg_out_r  <= '{1'b0, 1'b0, 2'h0, CLIENT_PRESET};
      chk_prot_r <= 1'b0;
    end else begin
      tg_s1_r    <= cfg_tgl_r;
      tg_s2_r    <= tg_s1_r;
      tg_s3_r    <= tg_s2_r;
      bz_s1_r    <= busy_r;
      bz_s2_r    <= bz_s1_r;
      cfg_out_r  <= (tg_s2_r ^ tg_s3_r) ? cfg_r : cfg_out_r;
      chk_prot_r <= cfg_out_r.pe &&
                    (chk_addr[`EECR_ZONE] >= ~cfg_out_r.pbs);
    end
  end

  assign sda_oe        = sda_oe_r;
  assign sda_o         = sda_o_r;
  assign cfg_out       = cfg_out_r;
  assign chk_protected = chk_prot_r;
  assign link_busy     = bz_s2_r;

  sequence s_addr_done;
    st_r == ST_ADDR && last_bit && !start_pend;
  endsequence

  sequence s_rd_start;
    s_addr_done ##0 (dev_match && byte_in[`EECR_RW_BIT]);
  endsequence

  AST_ADDR_ACK: assert property (
    @(posedge scl_in) disable iff (reset)
    s_addr_done ##0 dev_match |=> st_r == ST_AACK && sda_oe_r)
    else $error("matching address byte not acknowledged");

  AST_NO_MATCH: assert property (
    @(posedge scl_in) disable iff (reset)
    s_addr_done ##0 !dev_match |=> st_r == ST_IDLE && !sda_oe_r)
    else $error("foreign address byte acknowledged");

  AST_BYTE_LEN: assert property (
    @(posedge scl_in) disable iff (reset)
    s_rd_start ##1 (!start_pend) [*8] ##1 !start_pend
    |=> st_r == ST_RACK && !sda_oe_r)
    else $error("read byte not eight clocks long");

  AST_NACK_END: assert property (
    @(posedge scl_in) disable iff (reset)
    st_r == ST_RACK && sda_in && !start_pend
    |=> st_r == ST_IDLE && !sda_oe_r)
    else $error("device kept driving after host nack");

  AST_PTR_INC: assert property (
    @(posedge scl_in) disable iff (reset)
    load && !start_pend && !cfg_mode_r && !(&ptr_r)
    |=> ptr_r == $past(ptr_r) + 1 && obyte_r == mem[$past(ptr_r)])
    else $error("pointer not advanced past fetched byte");

  AST_WRAP: assert property (
    @(posedge scl_in) disable iff (reset)
    load && !start_pend && !cfg_mode_r && (&ptr_r)
    |=> ptr_r == `EECR_PTR_ZERO)
    else $error("pointer did not wrap at top of array");

  AST_PTR_LOAD: assert property (
    @(posedge scl_in) disable iff (reset)
    wa_done && !whi_r[`EECR_WA_CFG] |=> ptr_r == $past(word_ptr))
    else $error("word address not loaded into pointer");

  AST_LOCKED: assert property (
    @(posedge scl_in) disable iff (reset)
    cfg_r.lock |=> cfg_r.lock && $stable(cfg_r))
    else $error("locked configuration changed");

  AST_NO_WE: assert property (
    @(posedge scl_in) disable iff (reset)
    st_r == ST_WDAT && last_bit && cfg_mode_r && !byte_in[`EECR_B_WE]
    |=> $stable(cfg_r))
    else $error("config write taken without write enable");

  AST_CHK_BIT: assert property (
    @(posedge scl_in) disable iff (reset)
    st_r == ST_WDAT && last_bit && cfg_mode_r &&
    byte_in[`EECR_B_CHK] != byte_in[`EECR_B_LOCK] |=> $stable(cfg_r))
    else $error("config write taken with failed check bit");

  AST_RSV_ZERO: assert property (
    @(posedge scl_in) disable iff (reset)
    load && !start_pend && cfg_mode_r && cfg_idx_r == `EECR_PROT_IDX
    |=> obyte_r[7:4] == 4'h0)
    else $error("reserved protection bits read nonzero");

  AST_PROT_OFF: assert property (
    @(posedge clk) disable iff (reset)
    !cfg_out_r.pe |=> !chk_protected)
    else $error("address protected while protection disabled");

endmodule

// ### eecr_map.svh
// offsets, field positions and fixed counts of the eeprom read block
`ifndef EECR_MAP_SVH
`define EECR_MAP_SVH

`define EECR_AW         11
`define EECR_DEPTH      2048
`define EECR_PTR_ONE    11'h001
`define EECR_PTR_ZERO   11'h000
`define EECR_LAST_BIT   3'h7
`define EECR_FIRST_BIT  3'h1
`define EECR_BIT_ZERO   3'h0
`define EECR_NEXT_BIT   3'h6
`define EECR_DT_FIELD   7:4
`define EECR_CA_FIELD   3:1
`define EECR_RW_BIT     0
`define EECR_WA_CFG     7
`define EECR_WA_HI      2:0
`define EECR_B_WE       6
`define EECR_B_CHK      5
`define EECR_B_PE       3
`define EECR_PBS_FIELD  2:1
`define EECR_B_LOCK     0
`define EECR_CA_BITS    2:0
`define EECR_PROT_IDX   1'b0
`define EECR_ADDR_IDX   1'b1
`define EECR_RSV_PROT   4'h0
`define EECR_RSV_ADDR   5'h00
`define EECR_ZONE       10:9
`define EECR_DEV_TYPE   4'h5  // arbitrary device type value
`define EECR_CA_PRESET  3'h0

`endif

// ### eecr_pkg.sv
// types shared by the eeprom read and configuration block
`include "eecr_map.svh"

package eecr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_WHI   = 4'h3,
    ST_WHACK = 4'h4,
    ST_WLO   = 4'h5,
    ST_WLACK = 4'h6,
    ST_WDAT  = 4'h7,
    ST_WDACK = 4'h8,
    ST_RDAT  = 4'h9,
    ST_RACK  = 4'ha
  } eecr_state_t;

  typedef struct packed {
    logic       lock;
    logic       pe;
    logic [1:0] pbs;
    logic [2:0] caddr;
  } eecr_cfg_t;

  typedef logic [`EECR_AW-1:0] eecr_addr_t;

endpackage

// ### eecr_host_model.sv
// two-wire bus host model that drives the eeprom block's link
`timescale 1ns/1ps

module eecr_host_model (
  // link pins, sda is the resolved wire
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // scl only toggles inside frames, 32 ns a bit, data moves while low
  task automatic bitx(input logic b, output logic r);
    #8 sda_low = ~b;
    #8 scl = 1'b1;
    r = sda;
    #16 scl = 1'b0;
  endtask

  // also serves as a repeated start after a ninth clock, unless the device then drives a read bit on sda
  task automatic start;
    #8 sda_low = 1'b0;
    #8 scl = 1'b1;
    #8 sda_low = 1'b1;
    #8 scl = 1'b0;
  endtask

  task automatic stop;
    #8 sda_low = 1'b1;
    #8 scl = 1'b1;
    #8 sda_low = 1'b0;
    #16;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // released line floats high through the pull-up
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~ack, r);
  endtask
endmodule

// ### eecr_top_tb.sv
// self-checking bench for the eeprom read and configuration block
`timescale 1ns/1ps
`include "eecr_map.svh"

module eecr_top_tb;
  import eecr_pkg::*;
  logic       clk;
  logic       reset;
  logic       mem_wr_en;
  logic       sda_o;
  logic       sda_oe;
  logic       chk_protected;
  logic       link_busy;
  logic       scl_w;
  logic       host_low;
  logic       sda_w;
  eecr_addr_t mem_wr_addr;
  eecr_addr_t chk_addr;
  logic [7:0] mem_wr_data;
  eecr_cfg_t  cfg_out;
  logic [2:0] ca;
  int         err_total;
  int         n_compared;

  // open drain wire: low if either side pulls
  assign sda_w = ~(host_low | (sda_oe & ~sda_o));

  eecr_top eecr_top_inst (
    .clk          (clk),
    .reset        (reset),
    .scl_in       (scl_w),
    .sda_in       (sda_w),
    .sda_o        (sda_o),
    .sda_oe       (sda_oe),
    .mem_wr_en    (mem_wr_en),
    .mem_wr_addr  (mem_wr_addr),
    .mem_wr_data  (mem_wr_data),
    .chk_addr     (chk_addr),
    .chk_protected(chk_protected),
    .cfg_out      (cfg_out),
    .link_busy    (link_busy)
  );

  eecr_host_model eecr_host_model_inst (
    .scl    (scl_w),
    .sda_low(host_low),
    .sda    (sda_w)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // array pattern, distinct across the eight addresses that t_fill writes
  function automatic logic [7:0] mdat(input eecr_addr_t a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h3c;
  endfunction

  function automatic logic [7:0] dev(input logic rw);
    return {`EECR_DEV_TYPE, ca, rw};
  endfunction

  task automatic bus_start;
    eecr_host_model_inst.start;
  endtask

  task automatic bus_stop;
    eecr_host_model_inst.stop;
  endtask

  task automatic wb(input logic [7:0] d, input logic ack_exp);
    logic a;
    eecr_host_model_inst.wbyte(d, a);
    chk(11'(a), 11'(ack_exp));
  endtask

  task automatic rb(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    eecr_host_model_inst.rbyte(ack, d);
    chk(11'(d), 11'(exp));
  endtask

  // word address write, then repeated start into a read
  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    bus_start;
    wb(dev(1'b0), 1'b1);
    wb(hi, 1'b1);
    wb(lo, 1'b1);
    bus_start;
    wb(dev(1'b1), 1'b1);
  endtask

  task automatic cfg_wr(input logic [7:0] b0, input logic [7:0] b1,
                        input logic both);
    bus_start;
    wb(dev(1'b0), 1'b1);
    wb(8'h80, 1'b1);
    wb(8'h00, 1'b1);
    wb(b0, 1'b1);
    if (both)
      wb(b1, 1'b1);
    bus_stop;
    repeat (8) @(posedge clk);
    #1;
  endtask

  // upper word address bits other than the msb are junk on purpose
  task automatic cfg_rd(input logic [7:0] e0, input logic [7:0] e1);
    set_ptr(8'hb5, 8'h55);
    rb(1'b1, e0);
    rb(1'b0, e1);
    bus_stop;
  endtask

  task automatic prot(input logic [1:0] z, input logic exp);
    @(posedge clk);
    chk_addr <= {z, 9'h1ff};
    @(posedge clk);
    #1 chk(11'(chk_protected), 11'(exp));
  endtask

  task automatic t_fill;
    eecr_addr_t a;
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? 11'(i) : 11'(2040 + i);
      @(posedge clk);
      mem_wr_en <= 1'b1;
      mem_wr_addr <= a;
      mem_wr_data <= mdat(a);
    end
    @(posedge clk);
    mem_wr_en <= 1'b0;
  endtask

  // sequential read across the end of the array, then current read
  task automatic t_seq_read;
    set_ptr(8'h07, 8'hfe);
    rb(1'b1, mdat(11'h7fe));
    rb(1'b1, mdat(11'h7ff));
    rb(1'b0, mdat(11'h000));
    #4 chk(11'(sda_oe), 11'h000);
    bus_stop;
    bus_start;
    wb(dev(1'b1), 1'b1);
    rb(1'b0, mdat(11'h001));
    bus_stop;
    bus_start;
    wb({`EECR_DEV_TYPE ^ 4'h1, ca, 1'b1}, 1'b0);
    bus_stop;
  endtask

  // array data byte is acked but must not reach the array
  task automatic t_rand_one;
    bus_start;
    wb(dev(1'b0), 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h03, 1'b1);
    wb(8'hc3, 1'b1);
    bus_stop;
    set_ptr(8'h00, 8'h02);
    #1 chk(11'(link_busy), 11'h001);
    rb(1'b0, mdat(11'h002));
    bus_start;
    wb(dev(1'b1), 1'b1);
    rb(1'b0, mdat(11'h003));
    bus_stop;
    repeat (4) @(posedge clk);
    #1 chk(11'(link_busy), 11'h000);
  endtask

  task automatic t_cfg;
    cfg_rd(8'h00, {5'h00, ca});
    cfg_wr(8'h0e, 8'h00, 1'b0);
    cfg_wr(8'h6e, 8'h00, 1'b0);
    chk(11'(cfg_out), 11'(ca));
    for (int p = 0; p < 4; p++) begin
      cfg_wr({5'h09, 2'(p), 1'b0}, 8'h00, 1'b0);
      cfg_rd({5'h01, 2'(p), 1'b0}, {5'h00, ca});
      chk(11'(cfg_out), 11'({2'b01, 2'(p), ca}));
      for (int z = 0; z < 4; z++)
        prot(2'(z), z >= 3 - p);
    end
    cfg_wr(8'h46, 8'h00, 1'b0);
    prot(2'h3, 1'b0);
  endtask

  task automatic t_addr_lock;
    cfg_wr(8'h00, 8'h45, 1'b1);
    cfg_rd(8'h06, {5'h00, ca});
    cfg_wr(8'h00, 8'h65, 1'b1);
    bus_start;
    wb(dev(1'b1), 1'b0);
    bus_stop;
    ca = 3'h5;
    cfg_rd(8'h06, 8'h05);
    chk(11'(cfg_out), 11'({4'h3, ca}));
    cfg_wr(8'h41, 8'h00, 1'b0);
    chk(11'(cfg_out.lock), 11'h000);
    cfg_wr(8'h61, 8'h00, 1'b0);
    cfg_wr(8'h4e, 8'h62, 1'b1);
    cfg_rd(8'h01, 8'h05);
    chk(11'(cfg_out), 11'({4'h8, ca}));
  endtask

  initial begin
    reset = 1'b1;
    mem_wr_en = 1'b0;
    mem_wr_addr = '0;
    mem_wr_data = '0;
    chk_addr = '0;
    err_total = 0;
    n_compared = 0;
    ca = `EECR_CA_PRESET;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk(11'(cfg_out), 11'(ca));
    t_fill;
    t_seq_read;
    t_rand_one;
    t_cfg;
    t_addr_lock;
    tally_and_finish;
  end

  // whole run needs about 40 us of link traffic
  initial begin
    #300000;
    err_total++;
    tally_and_finish;
  end
endmodule
